// File: logic/car_pkg.sv
package car_pkg;

  // register map of the restart configuration
  localparam logic [7:0] FAULT_RESTART_CONFIG_ADDR = 8'h46;
  localparam logic [7:0] DONE_RESTART_CONFIG_ADDR = 8'h47;
  localparam logic [7:0] FAULT_RESTART_CONFIG_RST = 8'h00;
  localparam logic [7:0] DONE_RESTART_CONFIG_RST = 8'h00;

  // field positions in fault_restart_config
  localparam int DELAY_MSB = 7;
  localparam int DELAY_LSB = 4;
  localparam int VOLT_INH_BIT = 3;
  localparam int DISC_INH_BIT = 2;
  localparam int LOWBAT_INH_BIT = 1;
  localparam int TEMP_INH_BIT = 0;

  // field positions in done_restart_config
  localparam int DONE_EN_BIT = 7;
  localparam int DONE_PCT_MSB = 6;

  // encodings and percentages
  localparam logic [2:0] DONE_STAGE_CODE = 3'h4;
  localparam logic [6:0] DONE_PCT_MAX = 7'h63;  // 99 percent
  localparam logic [23:0] PCT_FULL = 24'h64;    // 100 percent
  localparam logic [23:0] PCT_RISE = 24'h69;    // 105 percent, a 5% rise
  localparam logic [23:0] PCT_NEAR_S2 = 24'h62; // 98 percent

  // timebase: one delay step is half an hour
  localparam longint unsigned CLK_HZ = 64'd100_000_000;
  localparam longint unsigned STEP_SECONDS = 64'd1800;
  localparam longint unsigned STEP_CYCLES = STEP_SECONDS * CLK_HZ;
  localparam int PRESCALE_W = 38;

  typedef struct packed {
    logic [7:0] faultCfg;
    logic [7:0] doneCfg;
    logic [7:0] rdData;
    logic [2:0] pendMask;
    logic [15:0] vbatAtFault;
    logic lockout;
    logic offSeen;
    logic enPrev;
    logic tempPrev;
    logic restart;
    logic timerReset;
    logic resume;
  } car_ctrl_s;

  typedef struct packed {
    logic busy;
    logic [PRESCALE_W-1:0] pre;
    logic [3:0] left;
    logic expired;
  } car_timer_s;

endpackage : car_pkg

// File: logic/car_delay_if.sv
`timescale 1ns/1ps
interface car_delay_if;
  logic start;
  logic cancel;
  logic [3:0] steps;
  logic expired;

  modport ctrl (output start, output cancel, output steps, input expired);
  modport timer (input start, input cancel, input steps, output expired);
endinterface : car_delay_if

// File: logic/car_delay_timer.sv
`timescale 1ns/1ps
module car_delay_timer
  import car_pkg::*;
#(
  parameter logic [PRESCALE_W-1:0] STEP_CNT = PRESCALE_W'(STEP_CYCLES)
) (
  input wire logic clk,
  input wire logic rst,
  car_delay_if.timer dly
);

  car_timer_s s_r;
  car_timer_s s_nxt;
  logic wrap;

  // prescaler ticks once per half-hour step, step counter counts down
  always_comb begin
    s_nxt = s_r;
    s_nxt.expired = 1'b0;
    wrap = (s_r.pre == STEP_CNT - PRESCALE_W'(1));
    if (s_r.busy) begin
      s_nxt.pre = wrap ? '0 : s_r.pre + PRESCALE_W'(1);
      if (wrap) begin
        s_nxt.left = s_r.left - 4'h1;
        if (s_r.left == 4'h1) begin
          s_nxt.busy = 1'b0;
          s_nxt.expired = 1'b1;
        end
      end
    end
    // a fresh fault restarts the whole delay; zero steps never arms
    if (dly.start) begin
      s_nxt.busy = (dly.steps != 4'h0);
      s_nxt.pre = '0;
      s_nxt.left = dly.steps;
      s_nxt.expired = 1'b0;
    end
    // cancel beats both start and expiry so no late restart escapes
    if (dly.cancel) begin
      s_nxt.busy = 1'b0;
      s_nxt.expired = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dly.expired = s_r.expired;

endmodule : car_delay_timer

// File: logic/car_restart_ctrl.sv
// What this block does
// - timer fault restarts Stage 0 after nibble delay
// - inhibited fault cancels pending delayed restart
// - stage2 timer fault restarts at vbat <= S1-S0
// - stage1 timer fault restarts on 5% rise/98%
// - stage0 timer fault restarts at vbat >= S0-S1
// - voltage inhibit blocks all three voltage restarts
// - disconnect inhibit stops until enable cycled
// - low-battery inhibit stops until enable cycled
// - temperature inhibit stops until enable cycled
// - every detected fault checked, not indication priority
// - done stage restarts when vbat below threshold
// - threshold is 1% steps of stage2, max 99
// - done stage means stage 100b and logic on
// - threshold follows compensated stage2 voltage when enabled
// - restart resets timers, temperature resume does not
`timescale 1ns/1ps
module car_restart_ctrl
  import car_pkg::*;
#(
  parameter logic [PRESCALE_W-1:0] STEP_CNT = PRESCALE_W'(STEP_CYCLES)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic chargeEnableControl,
  input wire logic stage0TimerExpiredFault,
  input wire logic stage1TimerExpiredFault,
  input wire logic stage2TimerExpiredFault,
  input wire logic batteryDisconnectFault,
  input wire logic lowBatteryFault,
  input wire logic batteryTemperatureFault,
  input wire logic [2:0] chargeStageField,
  input wire logic chargeLogicActive,
  input wire logic temperatureCompensationEnable,
  input wire logic [15:0] vbat,
  input wire logic [15:0] stage2Voltage,
  input wire logic [15:0] stage2VoltageComp,
  input wire logic [15:0] stage1ToStage0Threshold,
  input wire logic [15:0] stage0ToStage1Threshold,
  output logic restartStage0,
  output logic resetStageTimers,
  output logic resumeCharging,
  output logic chargeHalt
);

  // limits a user must know:
  // done restart repeats each cycle while vbat stays low;
  //   the stage logic must leave the done stage on the first pulse
  // a stage timer fault beats a restart condition in the same cycle,
  //   so that restart waits for the next clean cycle
  // the 5% rise is measured from vbat at the latest timer fault
  // halt drops only when charge is switched off with no inhibited
  //   fault present; a fault seen while off needs one more off/on
  // a half-hour step needs a very wide prescaler; simulation
  //   overrides STEP_CNT to keep runs short
  // products stay within 24 bits: 16-bit codes times at most 105

  car_ctrl_s s_r;
  car_ctrl_s s_nxt;
  car_delay_if dly ();

  logic [2:0] faultEvt;
  logic inhHit;
  logic doneStage;
  logic [15:0] vs2Eff;
  logic [6:0] donePct;
  logic [23:0] vbat100;
  logic [23:0] doneLimit;
  logic [23:0] riseLimit;
  logic [23:0] nearS2Limit;
  logic voltRestart;
  logic timerRestart;
  logic doneRestart;
  logic enFall;
  logic enRise;
  logic wrFault;
  logic wrDone;

  car_delay_timer #(
    .STEP_CNT(STEP_CNT)
  ) u_delay (
    .clk(clk),
    .rst(rst),
    .dly(dly.timer)
  );

  // scaled comparisons avoid a divider: compare vbat*100 to vs2*pct
  always_comb begin
    vs2Eff = temperatureCompensationEnable ? stage2VoltageComp
                                           : stage2Voltage;
    donePct = (s_r.doneCfg[DONE_PCT_MSB:0] > DONE_PCT_MAX) ? DONE_PCT_MAX
              : s_r.doneCfg[DONE_PCT_MSB:0];
    vbat100 = 24'(vbat) * PCT_FULL;
    doneLimit = 24'(vs2Eff) * 24'(donePct);
    riseLimit = 24'(s_r.vbatAtFault) * PCT_RISE;
    nearS2Limit = 24'(vs2Eff) * PCT_NEAR_S2;
    // done only counts while the charge logic is on
    doneStage = (chargeStageField == DONE_STAGE_CODE)
                && chargeLogicActive;
  end

  // fault qualification and restart conditions
  always_comb begin
    faultEvt = {stage2TimerExpiredFault, stage1TimerExpiredFault,
                stage0TimerExpiredFault};
    // every detected fault is checked, whatever the indication shows
    inhHit = (batteryDisconnectFault && s_r.faultCfg[DISC_INH_BIT])
           || (lowBatteryFault && s_r.faultCfg[LOWBAT_INH_BIT])
           || (batteryTemperatureFault && s_r.faultCfg[TEMP_INH_BIT]);
    voltRestart = !s_r.faultCfg[VOLT_INH_BIT] && (
        (s_r.pendMask[2] && vbat <= stage1ToStage0Threshold)
      || (s_r.pendMask[1] && (vbat100 >= riseLimit
                              || vbat100 >= nearS2Limit))
      || (s_r.pendMask[0] && vbat >= stage0ToStage1Threshold));
    // timer expiry is already registered, no extra stage here
    timerRestart = dly.expired;
    doneRestart = s_r.doneCfg[DONE_EN_BIT] && doneStage
                  && vbat100 < doneLimit;
    enFall = s_r.enPrev && !chargeEnableControl;
    enRise = !s_r.enPrev && chargeEnableControl;
    // one decoded strobe per register
    wrFault = regWrEn && (regAddr == FAULT_RESTART_CONFIG_ADDR);
    wrDone = regWrEn && (regAddr == DONE_RESTART_CONFIG_ADDR);
  end

  // main next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.restart = 1'b0;
    s_nxt.timerReset = 1'b0;
    s_nxt.resume = 1'b0;
    // enPrev resets low: the false rise after reset is harmless
    // because offSeen is clear then
    s_nxt.enPrev = chargeEnableControl;
    s_nxt.tempPrev = batteryTemperatureFault;
    dly.start = 1'b0;
    dly.cancel = 1'b0;
    dly.steps = s_r.faultCfg[DELAY_MSB:DELAY_LSB];

    if (wrFault) begin
      s_nxt.faultCfg = regWrData;
    end
    if (wrDone) begin
      s_nxt.doneCfg = regWrData;
    end
    // unmapped addresses read as zero
    unique case (regAddr)
      FAULT_RESTART_CONFIG_ADDR: s_nxt.rdData = s_r.faultCfg;
      DONE_RESTART_CONFIG_ADDR: s_nxt.rdData = s_r.doneCfg;
      default: s_nxt.rdData = 8'h00;
    endcase

    if (chargeEnableControl && !s_r.lockout) begin
      // a new stage timer fault arms both delay and voltage recovery
      if (|faultEvt) begin
        s_nxt.pendMask = s_r.pendMask | faultEvt;
        s_nxt.vbatAtFault = vbat;
        dly.start = 1'b1;
      end else if (timerRestart || voltRestart || doneRestart) begin
        s_nxt.pendMask = 3'h0;
        s_nxt.restart = 1'b1;
        s_nxt.timerReset = 1'b1;
        dly.cancel = 1'b1;
      end else if (s_r.tempPrev && !batteryTemperatureFault) begin
        s_nxt.resume = 1'b1;
      end
    end

    // an inhibited fault overrides any pending recovery
    if (inhHit) begin
      s_nxt.lockout = 1'b1;
      s_nxt.pendMask = 3'h0;
      s_nxt.restart = 1'b0;
      s_nxt.timerReset = 1'b0;
      s_nxt.resume = 1'b0;
      dly.start = 1'b0;
      dly.cancel = 1'b1;
    end

    // turning charge off drops all pending recovery
    if (enFall) begin
      s_nxt.offSeen = s_r.lockout;
      // set wins: a fault while switching off keeps the halt
      s_nxt.lockout = inhHit;
      s_nxt.pendMask = 3'h0;
      s_nxt.restart = 1'b0;
      s_nxt.timerReset = 1'b0;
      s_nxt.resume = 1'b0;
      dly.start = 1'b0;
      dly.cancel = 1'b1;
    end else if (enRise && s_r.offSeen && !s_r.lockout && !inhHit) begin
      // off-then-on after a lockout restarts charging fresh; a halt
      // taken while off is still standing, so no restart under it
      s_nxt.offSeen = 1'b0;
      s_nxt.restart = 1'b1;
      s_nxt.timerReset = 1'b1;
    end
  end

  // config registers return to their reset values with the state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.faultCfg <= FAULT_RESTART_CONFIG_RST;
      s_r.doneCfg <= DONE_RESTART_CONFIG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // all outputs straight from the state register
  assign regRdData = s_r.rdData;
  assign restartStage0 = s_r.restart;
  assign resetStageTimers = s_r.timerReset;
  assign resumeCharging = s_r.resume;
  assign chargeHalt = s_r.lockout;

endmodule : car_restart_ctrl

// File: dv/car_restart_ctrl_sva.sv
`timescale 1ns/1ps
module car_restart_ctrl_sva
  import car_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic chargeEnableControl,
  input wire logic stage0TimerExpiredFault,
  input wire logic stage1TimerExpiredFault,
  input wire logic stage2TimerExpiredFault,
  input wire logic batteryDisconnectFault,
  input wire logic lowBatteryFault,
  input wire logic batteryTemperatureFault,
  input wire logic [2:0] chargeStageField,
  input wire logic chargeLogicActive,
  input wire logic temperatureCompensationEnable,
  input wire logic [15:0] vbat,
  input wire logic [15:0] stage2Voltage,
  input wire logic [15:0] stage2VoltageComp,
  input wire logic [15:0] stage1ToStage0Threshold,
  input wire logic restartStage0,
  input wire logic resetStageTimers,
  input wire logic resumeCharging,
  input wire logic chargeHalt
);
  logic [7:0] fc;
  logic [7:0] dc;
  // shadow copies of both config registers, seen from the write port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fc <= 8'h00;
      dc <= 8'h00;
    end else if (regWrEn && regAddr == 8'h46) begin
      fc <= regWrData;
    end else if (regWrEn && regAddr == 8'h47) begin
      dc <= regWrData;
    end
  end
  // any inhibited fault present, and the plain "may act" condition
  wire logic tf = stage0TimerExpiredFault | stage1TimerExpiredFault |
    stage2TimerExpiredFault;
  wire logic inh = |(fc[2:0] & {batteryDisconnectFault, lowBatteryFault,
    batteryTemperatureFault});
  wire logic live = chargeEnableControl && !chargeHalt && !inh;
  // done threshold, clamped and widened so the products cannot wrap
  wire logic [6:0] pct = dc[6:0] > DONE_PCT_MAX ? DONE_PCT_MAX : dc[6:0];
  wire logic [31:0] ve = temperatureCompensationEnable ?
    32'(stage2VoltageComp) : 32'(stage2Voltage);
  wire logic low = 32'(vbat) * 32'h64 < ve * 32'(pct);
  wire logic dn = dc[7] && chargeStageField == DONE_STAGE_CODE &&
    chargeLogicActive;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_timer_reset_pair: assert property (
    resetStageTimers == restartStage0) else $error("timer reset unpaired");
  a_resume_keeps_timers: assert property (
    resumeCharging |-> !resetStageTimers) else $error("resume reset timers");
  a_halt_blocks_restart: assert property (
    chargeHalt |-> !restartStage0 && !resumeCharging)
    else $error("restart while halted");
  a_disconnect_halts: assert property (
    chargeEnableControl && fc[2] && batteryDisconnectFault |=> chargeHalt)
    else $error("disconnect did not halt");
  a_lowbat_halts: assert property (
    chargeEnableControl && fc[1] && lowBatteryFault |=> chargeHalt)
    else $error("low battery did not halt");
  a_temp_halts: assert property (
    chargeEnableControl && fc[0] && batteryTemperatureFault |=> chargeHalt)
    else $error("temperature did not halt");
  a_halt_holds: assert property (
    chargeHalt && chargeEnableControl |=> chargeHalt)
    else $error("halt dropped while enabled");
  a_stage2_volt_restart: assert property (
    live && stage2TimerExpiredFault ##1 live && !tf && !fc[3] &&
    vbat <= stage1ToStage0Threshold |=> restartStage0)
    else $error("stage2 voltage restart missing");
  a_done_restart: assert property (
    live && !tf && dn && low |=> restartStage0)
    else $error("done restart missing");

  cover property (restartStage0);
  cover property (resumeCharging);
  cover property ($fell(chargeHalt));
endmodule : car_restart_ctrl_sva

bind car_restart_ctrl car_restart_ctrl_sva i_car_restart_ctrl_sva (.*);

// File: dv/tb_car_restart_ctrl.sv
`timescale 1ns/1ps
module tb_car_restart_ctrl
  import car_pkg::*;
;
  typedef struct packed {
    logic [7:0] c;
    logic [2:0] t;
    logic [15:0] b;
    logic [15:0] v;
    logic e;
  } car_row_s;
  logic clk = 0, rst = 1, regWrEn = 0, chargeEnableControl = 1;
  logic [7:0] regAddr = 8'h46, regWrData = 8'h00, regRdData;
  logic [2:0] tf = 3'h0, flt = 3'h0, chargeStageField = 3'h0;
  logic chargeLogicActive = 0, temperatureCompensationEnable = 0;
  logic [15:0] vbat = 16'h0, stage2Voltage = 16'h578;
  logic [15:0] stage2VoltageComp = 16'h514;
  logic [15:0] stage1ToStage0Threshold = 16'h320;
  logic [15:0] stage0ToStage1Threshold = 16'h384;
  logic restartStage0, resetStageTimers, resumeCharging, chargeHalt;
  logic [15:0] rsCnt = 16'h0, rmCnt = 16'h0, r0, m0, k;
  logic [15:0] errTotal = 16'h0, testsRun = 16'h0, cycles = 16'h0;
  wire logic stage0TimerExpiredFault, stage1TimerExpiredFault;
  wire logic stage2TimerExpiredFault, batteryDisconnectFault;
  wire logic lowBatteryFault, batteryTemperatureFault;
  // fault vectors fanned out to the named pins
  assign {stage2TimerExpiredFault, stage1TimerExpiredFault,
    stage0TimerExpiredFault} = tf;
  assign {batteryDisconnectFault, lowBatteryFault,
    batteryTemperatureFault} = flt;
  // voltage-restart cases: config, timer fault, vbat at/after fault
  car_row_s rows[11] = '{
    '{8'h00, 3'h4, 16'h3e8, 16'h320, 1'b1},
    '{8'h00, 3'h4, 16'h3e8, 16'h321, 1'b0},
    '{8'h08, 3'h4, 16'h3e8, 16'h320, 1'b0},
    '{8'h00, 3'h2, 16'h3e8, 16'h41a, 1'b1},
    '{8'h00, 3'h2, 16'h3e8, 16'h419, 1'b0},
    '{8'h00, 3'h2, 16'h546, 16'h55c, 1'b1},
    '{8'h00, 3'h2, 16'h546, 16'h55b, 1'b0},
    '{8'h08, 3'h2, 16'h3e8, 16'h41a, 1'b0},
    '{8'h00, 3'h1, 16'h320, 16'h384, 1'b1},
    '{8'h00, 3'h1, 16'h320, 16'h383, 1'b0},
    '{8'h08, 3'h1, 16'h320, 16'h384, 1'b0}};

  car_restart_ctrl #(.STEP_CNT(PRESCALE_W'(4))) i_car_restart_ctrl (.*);

  always #5 clk = ~clk;

  // pulse counters and the hang guard
  always @(posedge clk) begin
    cycles <= cycles + 16'h1;
    if (restartStage0 === 1'b1) rsCnt <= rsCnt + 16'h1;
    if (resumeCharging === 1'b1) rmCnt <= rmCnt + 16'h1;
    if (cycles == 16'h7d0) begin
      errTotal = errTotal + 16'h1;
      giveVerdict();
    end
  end

  task giveVerdict();
    if (errTotal == 16'h0 && testsRun > 16'h0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : giveVerdict

  task chk(input logic [15:0] s, input logic [15:0] e);
    testsRun = testsRun + 16'h1;
    if (s !== e) begin
      errTotal = errTotal + 16'h1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // write, then read the same place back one cycle later
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    regAddr = a;
    regWrData = d;
    regWrEn = 1;
    cyc(1);
    regWrEn = 0;
    cyc(1);
    chk(regRdData, e);
  endtask : wr

  // off then on; also drops any pending restart
  task encyc();
    chargeEnableControl = 0;
    cyc(1);
    chargeEnableControl = 1;
    cyc(1);
  endtask : encyc

  // inhibited fault over a restart pending after a stage0 timer fault, then off/on
  task halt(input logic [7:0] c, input logic [2:0] f);
    encyc();
    wr(8'h46, c, c);
    tf = 3'h1;
    cyc(1);
    tf = 3'h0;
    flt = f;
    cyc(2);
    flt = 3'h0;
    r0 = rsCnt;
    cyc(10);
    chk(chargeHalt, 1);
    chk(rsCnt - r0, 0);
    encyc();
    cyc(3);
    chk(rsCnt - r0, 1);
    chk(chargeHalt, 0);
  endtask : halt

  // done-stage restart against threshold, compensation and clamp
  task dchk(input logic [7:0] d, input logic t, input logic a,
    input logic [15:0] v, input logic e);
    vbat = 16'hffff;
    temperatureCompensationEnable = t;
    chargeLogicActive = a;
    wr(8'h47, d, d);
    r0 = rsCnt;
    vbat = v;
    cyc(4);
    chk(16'(rsCnt != r0), 16'(e));
  endtask : dchk

  initial begin
    cyc(6);
    rst = 0;
    cyc(2);
    chk(regRdData, 0);
    wr(8'h48, 8'h33, 8'h00);
    // ordinary voltage-restart table
    foreach (rows[i]) begin
      encyc();
      wr(8'h46, rows[i].c, rows[i].c);
      vbat = rows[i].b;
      tf = rows[i].t;
      cyc(1);
      tf = 3'h0;
      vbat = rows[i].v;
      r0 = rsCnt;
      cyc(4);
      chk(16'(rsCnt != r0), 16'(rows[i].e));
    end
    // delayed restart, two steps of four cycles
    encyc();
    wr(8'h46, 8'h28, 8'h28);
    tf = 3'h1;
    cyc(1);
    tf = 3'h0;
    r0 = rsCnt;
    k = 16'h0;
    while (restartStage0 !== 1'b1 && k < 16'h28) begin
      cyc(1);
      k = k + 16'h1;
    end
    chk(k, 16'h9);
    halt(8'h2a, 3'h2);
    halt(8'h04, 3'h6);
    halt(8'h01, 3'h1);
    // uninhibited temperature fault resumes without a restart
    wr(8'h46, 8'h00, 8'h00);
    flt = 3'h1;
    cyc(2);
    m0 = rmCnt;
    r0 = rsCnt;
    flt = 3'h0;
    cyc(3);
    chk(rmCnt - m0, 1);
    chk(rsCnt - r0, 0);
    chargeStageField = 3'h4;
    dchk(8'hd5, 0, 1, 16'h4a6, 0);
    dchk(8'hd5, 0, 1, 16'h4a5, 1);
    dchk(8'hd5, 1, 1, 16'h4a5, 0);
    dchk(8'hd5, 1, 1, 16'h450, 1);
    dchk(8'hff, 1, 1, 16'h507, 0);
    dchk(8'hff, 1, 1, 16'h506, 1);
    dchk(8'hd5, 0, 0, 16'h000, 0);
    dchk(8'h55, 0, 1, 16'h000, 0);
    chargeStageField = 3'h3;
    dchk(8'hd5, 0, 1, 16'h000, 0);
    // halt, then a reset in mid-run clears halt and the fault config register
    wr(8'h46, 8'h01, 8'h01);
    flt = 3'h1;
    cyc(2);
    chk(chargeHalt, 1);
    rst = 1;
    flt = 3'h0;
    cyc(2);
    rst = 0;
    cyc(2);
    chk(chargeHalt, 0);
    chk(regRdData, 8'h00);
    giveVerdict();
  end
endmodule : tb_car_restart_ctrl
